// ==== inc/isd_pkg.sv ====
// Constants, types and helpers shared by the input sync timing diagnostics block
//
// Behaviour
// R1: Sync mode codes: 0 free run, 1 SM3, 2 SYNC0, 3 SYNC1, 34 SM2.
// R2: Shift time reports SYNC0 to input sampling delay in ns, read-only, DC only.
// R3: Supported modes bit 0 set: free run available.
// R4: Supported modes bit 1: sync to sync-manager event supported.
// R5: Supported modes bits 3:2 hold 01: distributed clock supported.
// R6: Supported modes bits 5:4: 01 local event shift, 10 SYNC1 shift.
// R7: Supported modes bit 14 marks dynamic, measurable timing values.
// R8: Minimum cycle time reads 66000 ns, read-only.
// R9: Calc and copy time: sampling to inputs ready, default 66000 ns, DC only.
// R10: Minimum SYNC1 delay reads zero ns, read-only.
// R11: Command 1 starts measurement, 0 stops it.
// R12: While measuring, shift, calc-copy, max delay keep largest observed values.
// R13: Starting a measurement clears previously captured maximum values.
// R14: Maximum SYNC1 to sampling delay in ns, read-only, DC only.
// R15: 16-bit count of missed sync-manager events in operational DC mode.
// R16: 16-bit count of late cycle ends or early cycle starts in operational.
// R17: 16-bit count of too short SYNC0 to SYNC1 intervals in DC mode.
// R18: Sync error flag shows last DC cycle was not correctly synchronized.
// R19: Counters and flag clear on reset; counters saturate, never wrap.
package isd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [5:0] OFS_SYNC_MODE      = 6'h00;
	localparam logic [5:0] OFS_SHIFT_TIME     = 6'h04;
	localparam logic [5:0] OFS_SUPPORTED      = 6'h08;
	localparam logic [5:0] OFS_MIN_CYCLE      = 6'h0C;
	localparam logic [5:0] OFS_CALC_COPY      = 6'h10;
	localparam logic [5:0] OFS_MIN_SYNC1      = 6'h14;
	localparam logic [5:0] OFS_MEAS_CMD       = 6'h18;
	localparam logic [5:0] OFS_MAX_SYNC1      = 6'h1C;
	localparam logic [5:0] OFS_MISSED         = 6'h20;
	localparam logic [5:0] OFS_OVERRUN        = 6'h24;
	localparam logic [5:0] OFS_SHORT_SHIFT    = 6'h28;
	localparam logic [5:0] OFS_SYNC_ERR       = 6'h2C;

	////////////////////////////////////////////////////////////////////////////////
	// Sync mode codes and reset values
	localparam logic [15:0] MODE_FREE_RUN     = 16'h0000;
	localparam logic [15:0] MODE_SM3          = 16'h0001;
	localparam logic [15:0] MODE_SYNC0        = 16'h0002;
	localparam logic [15:0] MODE_SYNC1        = 16'h0003;
	localparam logic [15:0] MODE_SM2          = 16'h0022;
	localparam logic [15:0] SYNC_MODE_RST     = 16'h0022;
	localparam logic [15:0] MEAS_CMD_RST      = 16'h0000;
	localparam logic [15:0] MEAS_CMD_START    = 16'h0001;
	localparam logic [15:0] MEAS_CMD_STOP     = 16'h0000;
	localparam logic [31:0] SHIFT_TIME_RST    = 32'h0000_0000;
	localparam logic [31:0] MIN_CYCLE_NS      = 32'h0001_01D0;
	localparam logic [31:0] CALC_COPY_RST     = 32'h0001_01D0;
	localparam logic [31:0] MIN_SYNC1_NS      = 32'h0000_0000;
	localparam logic [31:0] MAX_SYNC1_RST     = 32'h0000_0000;
	localparam logic [15:0] CNT_RST           = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Supported modes word fields
	localparam int          SSM_FREE_POS      = 0;
	localparam int          SSM_SM_POS        = 1;
	localparam int          SSM_DC_LSB        = 2;
	localparam int          SSM_SHIFT_LSB     = 4;
	localparam int          SSM_AUX_POS       = 11;
	localparam int          SSM_DYN_POS       = 14;
	localparam logic [1:0]  SSM_DC_VAL        = 2'h1;
	localparam logic [1:0]  SSM_SHIFT_LOCAL   = 2'h1;
	localparam logic [1:0]  SSM_SHIFT_SYNC1   = 2'h2;
	localparam logic [1:0]  SSM_SHIFT_VAL     = 2'h0;
	localparam logic        SSM_DYN_VAL       = 1'b0;
	localparam logic [15:0] SSM_RST           = 16'h0807;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int          CLK_PERIOD_NS     = 20;
	localparam logic [31:0] CLK_NS            = 32'(CLK_PERIOD_NS);
	localparam logic [31:0] TIMER_MAX         = 32'h0CCC_CCCC;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Event carrier from the synchronisation logic
	typedef struct packed {
		logic op_state;       // Operational state level
		logic sync0;          // SYNC0 event pulse
		logic sync1;          // SYNC1 event pulse
		logic sample;         // Inputs sampled pulse
		logic ready;          // Inputs ready for master pulse
		logic sm_missed;      // Sync-manager event missed pulse
		logic cycle_late;     // Cycle late or early start pulse
		logic shift_short;    // SYNC0 to SYNC1 too short pulse
		logic out_late;       // Outputs driven late pulse
	} isd_evt_t;

	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} isd_rd_state_t;

	// Cycle count to nanoseconds
	function automatic logic [31:0] cyc_to_ns(input logic [31:0] c);
		return c * CLK_NS;
	endfunction

	// Saturating timer step
	function automatic logic [31:0] timer_step(input logic [31:0] c);
		return (c >= TIMER_MAX) ? TIMER_MAX : c + 32'h0000_0001;
	endfunction

endpackage

// ==== src/isd_max_hold.sv ====
// Largest-value capture register with clear
`timescale 1ns/10ps
module isd_max_hold
#(
	parameter logic [31:0] RST_VAL = 32'h0000_0000
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clr,
	input  wire logic        load,
	input  wire logic [31:0] value,
	output logic [31:0]      max_r
);
	import isd_pkg::*;

	logic [31:0] max_nxt;

	// Clear first, then keep the larger value
	always_comb
	begin
		max_nxt = max_r;
		if (clr)
			max_nxt = 32'h0000_0000; // R13
		else if (load && value > max_r)
			max_nxt = value; // R12
	end

	// Maximum register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			max_r <= RST_VAL;
		else
			max_r <= max_nxt;
	end
endmodule // isd_max_hold

// ==== src/isd_sat_cnt.sv ====
// Saturating 16-bit event counter
`timescale 1ns/10ps
module isd_sat_cnt
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        inc,
	output logic [15:0]      count_r
);
	import isd_pkg::*;

	logic [15:0] count_nxt;

	// Next count, held at all ones
	always_comb
	begin
		count_nxt = count_r;
		if (inc && count_r != 16'hFFFF)
			count_nxt = count_r + 16'h0001; // R19
	end

	// Count register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_r <= CNT_RST; // R19
		else
			count_r <= count_nxt;
	end
endmodule // isd_sat_cnt

// ==== src/isd_top.sv ====
// Input sync timing diagnostics register bank with AXI4-Lite slave
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module isd_top
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Write address channel
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [5:0]    s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	// Write data channel
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	// Write response channel
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	output logic [1:0]         s_axi_bresp,
	// Read address channel
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	input  wire logic [5:0]    s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	// Read data channel
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	// Synchronisation events
	input  wire isd_pkg::isd_evt_t evt,
	// Status
	output logic               meas_running,
	output logic               dc_mode
);
	import isd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic        awready_r, awready_nxt;
	logic        wready_r, wready_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        aw_have_r, aw_have_nxt;
	logic        w_have_r, w_have_nxt;
	logic [5:0]  awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;

	isd_rd_state_t rd_state_r, rd_state_nxt;
	logic        arready_r, arready_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;

	logic [15:0] sync_mode_r, sync_mode_nxt;
	logic [15:0] meas_cmd_r, meas_cmd_nxt;
	logic        meas_r, meas_nxt;
	logic        meas_clr_r, meas_clr_nxt;
	logic        dc_r, dc_nxt;

	logic [31:0] since_sync0_r, since_sync0_nxt;
	logic [31:0] since_sync1_r, since_sync1_nxt;
	logic [31:0] since_sample_r, since_sample_nxt;
	logic        late_seen_r, late_seen_nxt;
	logic        sync_err_r, sync_err_nxt;

	logic        wr_fire;
	logic [31:0] shift_time;
	logic [31:0] calc_copy;
	logic [31:0] max_sync1;
	logic [15:0] missed_cnt;
	logic [15:0] overrun_cnt;
	logic [15:0] short_cnt;
	logic        cap_sample;
	logic        cap_ready;
	logic        inc_missed;
	logic        inc_overrun;
	logic        inc_short;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge write data into a 16-bit register by byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[15:8] = d[15:8];
		return r;
	endfunction

	// Address is a mapped register
	function automatic logic is_mapped(input logic [5:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_SYNC_ERR);
	endfunction

	// Supported modes word built from its fields
	function automatic logic [15:0] supported_word();
		logic [15:0] w;
		w = 16'h0000;
		w[SSM_FREE_POS] = 1'b1; // R3
		w[SSM_SM_POS] = 1'b1; // R4
		w[SSM_DC_LSB +: 2] = SSM_DC_VAL; // R5
		w[SSM_SHIFT_LSB +: 2] = SSM_SHIFT_VAL; // R6
		w[SSM_AUX_POS] = SSM_RST[SSM_AUX_POS];
		w[SSM_DYN_POS] = SSM_DYN_VAL; // R7
		return w;
	endfunction

	// Read data for an address
	function automatic logic [31:0] rd_mux(input logic [5:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			OFS_SYNC_MODE:   d = {16'h0000, sync_mode_r};
			OFS_SHIFT_TIME:  d = shift_time; // R2
			OFS_SUPPORTED:   d = {16'h0000, supported_word()};
			OFS_MIN_CYCLE:   d = MIN_CYCLE_NS; // R8
			OFS_CALC_COPY:   d = calc_copy; // R9
			OFS_MIN_SYNC1:   d = MIN_SYNC1_NS; // R10
			OFS_MEAS_CMD:    d = {16'h0000, meas_cmd_r};
			OFS_MAX_SYNC1:   d = max_sync1; // R14
			OFS_MISSED:      d = {16'h0000, missed_cnt};
			OFS_OVERRUN:     d = {16'h0000, overrun_cnt};
			OFS_SHORT_SHIFT: d = {16'h0000, short_cnt};
			OFS_SYNC_ERR:    d = {31'h0000_0000, sync_err_r}; // R18
			default:         d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Write channels: address and data taken in either order

	assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

	// Write channel next state
	always_comb
	begin
		awready_nxt = awready_r;
		wready_nxt  = wready_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_have_nxt = 1'b1;
			awready_nxt = 1'b0;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_have_nxt = 1'b1;
			wready_nxt = 1'b0;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready)
		begin
			bvalid_nxt  = 1'b0;
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			awready_nxt = 1'b1;
			wready_nxt  = 1'b1;
		end
	end

	// Write channel registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_r  <= 6'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end
		else
		begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel

	// Read channel next state
	always_comb
	begin
		rd_state_nxt = rd_state_r;
		arready_nxt  = arready_r;
		rdata_nxt    = rdata_r;
		rresp_nxt    = rresp_r;
		unique case (rd_state_r)
			RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					rd_state_nxt = RD_DATA;
					arready_nxt  = 1'b0;
					rdata_nxt    = is_mapped(s_axi_araddr) ? rd_mux(s_axi_araddr)
						: 32'h0000_0000;
					rresp_nxt    = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				end
			end
			RD_DATA:
			begin
				if (s_axi_rready)
				begin
					rd_state_nxt = RD_IDLE;
					arready_nxt  = 1'b1;
				end
			end
		endcase
	end

	// Read channel registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_r <= RD_IDLE;
			arready_r  <= 1'b1;
			rdata_r    <= 32'h0000_0000;
			rresp_r    <= RESP_OKAY;
		end
		else
		begin
			rd_state_r <= rd_state_nxt;
			arready_r  <= arready_nxt;
			rdata_r    <= rdata_nxt;
			rresp_r    <= rresp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers and measurement control

	// Control next state
	always_comb
	begin
		sync_mode_nxt = sync_mode_r;
		meas_cmd_nxt  = meas_cmd_r;
		meas_clr_nxt  = 1'b0;
		if (wr_fire && awaddr_r == OFS_SYNC_MODE)
			sync_mode_nxt = merge16(sync_mode_r, wdata_r, wstrb_r);
		if (wr_fire && awaddr_r == OFS_MEAS_CMD)
		begin
			meas_cmd_nxt = merge16(meas_cmd_r, wdata_r, wstrb_r);
			meas_clr_nxt = (merge16(meas_cmd_r, wdata_r, wstrb_r) == MEAS_CMD_START); // R13
		end
		meas_nxt = (meas_cmd_nxt == MEAS_CMD_START); // R11
		dc_nxt   = (sync_mode_nxt == MODE_SYNC0) || (sync_mode_nxt == MODE_SYNC1); // R1
	end

	// Control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_mode_r <= SYNC_MODE_RST;
			meas_cmd_r  <= MEAS_CMD_RST;
			meas_r      <= 1'b0;
			meas_clr_r  <= 1'b0;
			dc_r        <= 1'b0;
		end
		else
		begin
			sync_mode_r <= sync_mode_nxt;
			meas_cmd_r  <= meas_cmd_nxt;
			meas_r      <= meas_nxt;
			meas_clr_r  <= meas_clr_nxt;
			dc_r        <= dc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interval timers and sync error flag

	// Timers restart on their event, saturate otherwise
	always_comb
	begin
		since_sync0_nxt  = evt.sync0 ? 32'h0000_0000 : timer_step(since_sync0_r);
		since_sync1_nxt  = evt.sync1 ? 32'h0000_0000 : timer_step(since_sync1_r);
		since_sample_nxt = evt.sample ? 32'h0000_0000 : timer_step(since_sample_r);
		late_seen_nxt    = late_seen_r || evt.out_late;
		sync_err_nxt     = sync_err_r;
		if (evt.sync0)
		begin
			late_seen_nxt = evt.out_late;
			if (dc_r)
				sync_err_nxt = late_seen_r; // R18
		end
	end

	// Timer registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			since_sync0_r  <= 32'h0000_0000;
			since_sync1_r  <= 32'h0000_0000;
			since_sample_r <= 32'h0000_0000;
			late_seen_r    <= 1'b0;
			sync_err_r     <= 1'b0; // R19
		end
		else
		begin
			since_sync0_r  <= since_sync0_nxt;
			since_sync1_r  <= since_sync1_nxt;
			since_sample_r <= since_sample_nxt;
			late_seen_r    <= late_seen_nxt;
			sync_err_r     <= sync_err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Maximum capture and diagnostic counters

	// Capture and count qualifiers
	assign cap_sample  = meas_r && dc_r && evt.sample; // R12
	assign cap_ready   = meas_r && dc_r && evt.ready; // R12
	assign inc_missed  = evt.sm_missed && evt.op_state && dc_r; // R15
	assign inc_overrun = evt.cycle_late && evt.op_state; // R16
	assign inc_short   = evt.shift_short && dc_r; // R17

	isd_max_hold #(.RST_VAL(SHIFT_TIME_RST)) u_shift
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (meas_clr_r),
		.load    (cap_sample),
		.value   (cyc_to_ns(since_sync0_r)),
		.max_r   (shift_time)
	);

	isd_max_hold #(.RST_VAL(CALC_COPY_RST)) u_calc
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (meas_clr_r),
		.load    (cap_ready),
		.value   (cyc_to_ns(since_sample_r)),
		.max_r   (calc_copy)
	);

	isd_max_hold #(.RST_VAL(MAX_SYNC1_RST)) u_sync1
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (meas_clr_r),
		.load    (cap_sample),
		.value   (cyc_to_ns(since_sync1_r)),
		.max_r   (max_sync1)
	);

	isd_sat_cnt u_missed
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.inc     (inc_missed),
		.count_r (missed_cnt)
	);

	isd_sat_cnt u_overrun
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.inc     (inc_overrun),
		.count_r (overrun_cnt)
	);

	isd_sat_cnt u_short
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.inc     (inc_short),
		.count_r (short_cnt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs from flip-flops

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = (rd_state_r == RD_DATA);
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign meas_running  = meas_r;
	assign dc_mode       = dc_r;

endmodule // isd_top

// ==== verification/isd_evt_src.sv ====
// Event source standing in for the fieldbus side of the sync logic
`timescale 1ns/10ps
module isd_evt_src
(
	input  wire logic      aclk,
	output isd_pkg::isd_evt_t evt
);
	import isd_pkg::*;

	initial evt = '0;

	// Operational state level
	task automatic set_op(input logic v);
		@(posedge aclk);
		evt.op_state <= v;
	endtask

	// One-cycle pulses, then quiet
	task automatic fire(input logic [7:0] p);
		@(posedge aclk);
		evt[7:0] <= p;
		@(posedge aclk);
		evt[7:0] <= 8'h00;
	endtask

	// Sync edges together, then sampling, then hand-over
	task automatic dc_cycle(input int g, input int h);
		fire(8'hC0);
		repeat (g) @(posedge aclk);
		fire(8'h20);
		repeat (h) @(posedge aclk);
		fire(8'h10);
	endtask
endmodule // isd_evt_src

// ==== verification/isd_properties.sv ====
// Port-level checker for the sync diagnostics register bank
`timescale 1ns/10ps
module isd_props
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [5:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [5:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        meas_running,
	input wire logic        dc_mode
);
	import isd_pkg::*;
	logic [5:0]  aw_r;
	logic [5:0]  aw_nxt;
	logic [15:0] wd_r;
	logic [15:0] wd_nxt;
	logic        ar_hs;

	// Last write address and data taken
	always_comb
	begin
		aw_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_r;
		wd_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[15:0] : wd_r;
		ar_hs = s_axi_arvalid && s_axi_arready;
	end

	always_ff @(posedge aclk)
	begin
		aw_r <= aresetn ? aw_nxt : 6'h00;
		wd_r <= aresetn ? wd_nxt : 16'h0000;
	end

	////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped early");
	AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during read");
	AST_RD_REFUSE: assert property (ar_hs && (s_axi_araddr[1:0] != 2'h0
		|| s_axi_araddr > 6'h2C) |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		&& s_axi_rdata == 32'h0000_0000) else $error("bad read not refused");
	AST_WR_REFUSE: assert property ($rose(s_axi_bvalid) && (aw_r[1:0] != 2'h0
		|| aw_r > 6'h2C) |-> s_axi_bresp == RESP_SLVERR) else $error("bad write not refused");
	AST_MIN_CYCLE: assert property (ar_hs && s_axi_araddr == OFS_MIN_CYCLE
		|=> s_axi_rdata == MIN_CYCLE_NS) else $error("minimum cycle time wrong");
	AST_SUP_MODES: assert property (ar_hs && s_axi_araddr == OFS_SUPPORTED
		|=> s_axi_rdata == {16'h0000, SSM_RST}) else $error("supported modes wrong");
	AST_MEAS_ON: assert property ($rose(s_axi_bvalid) && aw_r == OFS_MEAS_CMD
		&& wd_r == MEAS_CMD_START |=> meas_running) else $error("measurement not started");
	AST_MEAS_OFF: assert property ($rose(s_axi_bvalid) && aw_r == OFS_MEAS_CMD
		&& wd_r != MEAS_CMD_START |=> !meas_running) else $error("measurement not stopped");
	AST_DC_MODE: assert property ($rose(s_axi_bvalid) && aw_r == OFS_SYNC_MODE
		|=> dc_mode == (wd_r == MODE_SYNC0 || wd_r == MODE_SYNC1)) else $error("dc mode wrong");
endmodule // isd_props

bind isd_top isd_props u_isd_props (.*);

// ==== verification/tb.sv ====
// Self-checking bench for the sync diagnostics register bank
`timescale 1ns/10ps
module tb;
	import isd_pkg::*;
	localparam logic [7:0] S0 = 8'h80;
	localparam logic [7:0] MISS = 8'h08;
	localparam logic [7:0] LATE = 8'h04;
	localparam logic [7:0] SHORT = 8'h02;
	localparam logic [7:0] OUTL = 8'h01;
	logic        aclk;
	logic        aresetn;
	logic        awv;
	logic        wv;
	logic        bry;
	logic        arv;
	logic        rry;
	logic [5:0]  awa;
	logic [5:0]  ara;
	logic [31:0] wd;
	logic        awrdy;
	logic        wrdy;
	logic        bvld;
	logic        arrdy;
	logic        rvld;
	logic        meas;
	logic        dcm;
	logic [1:0]  brsp;
	logic [1:0]  rrsp;
	logic [1:0]  rsp;
	logic [31:0] rdat;
	logic [31:0] dat;
	logic [3:0]  ws;
	logic [2:0]  prot;
	isd_evt_t    evt;
	int          fail_count;
	int          checks_done;
	int          cyc;

	isd_top u_isd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
		.s_axi_awready(awrdy), .s_axi_awaddr(awa), .s_axi_awprot(prot),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bvld), .s_axi_bready(bry), .s_axi_bresp(brsp),
		.s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_araddr(ara),
		.s_axi_arprot(prot), .s_axi_rvalid(rvld), .s_axi_rready(rry),
		.s_axi_rdata(rdat), .s_axi_rresp(rrsp), .evt(evt), .meas_running(meas),
		.dc_mode(dcm));
	isd_evt_src u_isd_evt_src (.aclk(aclk), .evt(evt));

	////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			wrap_up;
		end
	end

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: data %h want %h", $time, g, e);
		end
	endtask

	task automatic chkr(input logic [1:0] g, input logic [1:0] e);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: resp %h want %h", $time, g, e);
		end
	endtask

	////////////////////////////////////////
	// Bus write
	task automatic axw(input logic [5:0] a, input logic [31:0] d);
		@(posedge aclk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		do
		begin
			@(posedge aclk);
			if (awv && awrdy)
				awv <= 1'b0;
			if (wv && wrdy)
				wv <= 1'b0;
		end
		while (bvld !== 1'b1);
		bry <= 1'b1;
		@(posedge aclk);
		rsp = brsp;
		bry <= 1'b0;
	endtask

	// Bus read
	task automatic axr(input logic [5:0] a);
		@(posedge aclk);
		arv <= 1'b1;
		ara <= a;
		do
		begin
			@(posedge aclk);
			if (arv && arrdy)
				arv <= 1'b0;
		end
		while (rvld !== 1'b1);
		rry <= 1'b1;
		@(posedge aclk);
		dat = rdat;
		rsp = rrsp;
		rry <= 1'b0;
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		axr(a);
		chk(dat, e);
		chkr(rsp, RESP_OKAY);
	endtask

	////////////////////////////////////////
	// Reset values and read-only registers
	task automatic t_reset;
		logic [31:0] e [12] = '{32'(SYNC_MODE_RST), SHIFT_TIME_RST, 32'(SSM_RST),
			MIN_CYCLE_NS, CALC_COPY_RST, MIN_SYNC1_NS, 32'(MEAS_CMD_RST), MAX_SYNC1_RST,
			32'(CNT_RST), 32'(CNT_RST), 32'(CNT_RST), 32'h0000_0000};
		for (int i = 0; i < 12; i++)
			rdc(6'(i * 4), e[i]);
		axw(OFS_MIN_CYCLE, 32'hFFFF_FFFF);
		rdc(OFS_MIN_CYCLE, MIN_CYCLE_NS);
		axw(OFS_SUPPORTED, 32'h0000_0000);
		rdc(OFS_SUPPORTED, 32'(SSM_RST));
	endtask

	// Unmapped and unaligned accesses
	task automatic t_refuse;
		axw(6'h30, 32'h0000_0001);
		chkr(rsp, RESP_SLVERR);
		axw(6'h1A, 32'h0000_0001);
		chkr(rsp, RESP_SLVERR);
		rdc(OFS_MEAS_CMD, 32'h0000_0000);
		axr(6'h3C);
		chkr(rsp, RESP_SLVERR);
		chk(dat, 32'h0000_0000);
		axr(6'h05);
		chkr(rsp, RESP_SLVERR);
	endtask

	// Every sync mode code and the dc flag it gives
	task automatic t_modes;
		logic [15:0] m [5] = '{MODE_FREE_RUN, MODE_SM3, MODE_SYNC0, MODE_SYNC1, MODE_SM2};
		for (int i = 0; i < 5; i++)
		begin
			axw(OFS_SYNC_MODE, 32'(m[i]));
			rdc(OFS_SYNC_MODE, 32'(m[i]));
			chk(32'(dcm), 32'(i == 2 || i == 3));
		end
		ws <= 4'h2;
		axw(OFS_SYNC_MODE, 32'h0000_FF03);
		ws <= 4'hF;
		rdc(OFS_SYNC_MODE, 32'h0000_FF22);
	endtask

	// Counter qualifiers: operational state and dc mode
	task automatic t_counters;
		axw(OFS_SYNC_MODE, 32'(MODE_SYNC0));
		u_isd_evt_src.set_op(1'b1);
		repeat (3) u_isd_evt_src.fire(MISS);
		repeat (2) u_isd_evt_src.fire(LATE);
		u_isd_evt_src.fire(SHORT);
		rdc(OFS_MISSED, 32'd3);
		rdc(OFS_OVERRUN, 32'd2);
		rdc(OFS_SHORT_SHIFT, 32'd1);
		u_isd_evt_src.set_op(1'b0);
		u_isd_evt_src.fire(MISS | LATE | SHORT);
		rdc(OFS_MISSED, 32'd3);
		rdc(OFS_OVERRUN, 32'd2);
		rdc(OFS_SHORT_SHIFT, 32'd2);
		axw(OFS_SYNC_MODE, 32'(MODE_SM2));
		u_isd_evt_src.set_op(1'b1);
		u_isd_evt_src.fire(MISS | LATE | SHORT);
		rdc(OFS_MISSED, 32'd3);
		rdc(OFS_OVERRUN, 32'd3);
		rdc(OFS_SHORT_SHIFT, 32'd2);
		u_isd_evt_src.set_op(1'b0);
	endtask

	// Late outputs latched per sync cycle
	task automatic t_sync_err;
		axw(OFS_SYNC_MODE, 32'(MODE_SYNC0));
		u_isd_evt_src.fire(S0);
		u_isd_evt_src.fire(OUTL);
		u_isd_evt_src.fire(S0);
		rdc(OFS_SYNC_ERR, 32'd1);
		u_isd_evt_src.fire(S0 | OUTL);
		rdc(OFS_SYNC_ERR, 32'd0);
		u_isd_evt_src.fire(S0);
		rdc(OFS_SYNC_ERR, 32'd1);
	endtask

	// Start, track maxima, stop, restart clears
	task automatic t_measure;
		axw(OFS_MEAS_CMD, 32'(MEAS_CMD_START));
		rdc(OFS_MEAS_CMD, 32'd1);
		chk(32'(meas), 32'd1);
		rdc(OFS_CALC_COPY, 32'd0);
		u_isd_evt_src.dc_cycle(3, 3);
		rdc(OFS_SHIFT_TIME, 32'h50);
		rdc(OFS_CALC_COPY, 32'h50);
		rdc(OFS_MAX_SYNC1, 32'h50);
		u_isd_evt_src.dc_cycle(8, 8);
		rdc(OFS_SHIFT_TIME, 32'hB4);
		rdc(OFS_CALC_COPY, 32'hB4);
		rdc(OFS_MAX_SYNC1, 32'hB4);
		u_isd_evt_src.dc_cycle(3, 3);
		rdc(OFS_SHIFT_TIME, 32'hB4);
		axw(OFS_MEAS_CMD, 32'(MEAS_CMD_STOP));
		rdc(OFS_MEAS_CMD, 32'd0);
		chk(32'(meas), 32'd0);
		u_isd_evt_src.dc_cycle(12, 12);
		rdc(OFS_CALC_COPY, 32'hB4);
		axw(OFS_MEAS_CMD, 32'(MEAS_CMD_START));
		rdc(OFS_SHIFT_TIME, 32'd0);
		rdc(OFS_MAX_SYNC1, 32'd0);
	endtask

	////////////////////////////////////////
	initial
	begin
		aresetn = 1'b0;
		awv = 1'b0;
		wv = 1'b0;
		bry = 1'b0;
		arv = 1'b0;
		rry = 1'b0;
		awa = 6'h00;
		ara = 6'h00;
		wd = 32'h0000_0000;
		ws = 4'hF;
		prot = 3'h0;
		fail_count = 0;
		checks_done = 0;
		cyc = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_refuse;
		t_modes;
		t_counters;
		t_sync_err;
		t_measure;
		wrap_up;
	end
endmodule // tb
